// [rtl/pfl_function_ctrl.sv]
`timescale 1ns/100ps
module pfl_function_ctrl
  import pfl_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic latchEnablePin,
  input wire logic chipEnablePin,
  input wire logic chargePumpEvent,
  input wire logic pfdTick,
  input wire logic lockDetect,
  input wire logic refDivOut,
  input wire logic fbDivOut,
  output logic monitorOutputPin,
  output pfl_ctrl_t ctrl,
  output logic powerDown,
  output logic [2:0] chargePumpCurrent,
  output logic [1:0] prescalerSelect,
  output logic pdPolarity,
  output logic fastActive,
  output logic refLoad,
  output logic fbLoad,
  output logic [WORD_W-1:0] counterWord
);

  // does a captured word target the given latch
  function automatic logic latchIs(input logic [WORD_W-1:0] w, input logic [1:0] code);
    latchIs = (w[SEL_W-1:0] == code);
  endfunction

  // timeout length in phase detector cycles for a select code
  function automatic logic [5:0] timeoutLen(input logic [3:0] sel);
    timeoutLen = TMO_BASE + 6'(sel) * TMO_STEP;
  endfunction

  // ---------------- link domain ----------------
  logic [WORD_W-1:0] shiftReg; // serial input register, msb first

  // shift on each rising serial clock; never gated by power-down so
  // programming works with the device disabled
  always_ff @(posedge serialClk) begin
    shiftReg <= {shiftReg[WORD_W-2:0], serialData};
  end

  // ---------------- crossings ----------------
  logic leMeta; // first stage, read only by leSync
  logic leSync; // synchronised latch enable
  logic leLast; // previous synchronised value
  logic ceMeta; // first stage, read only by ceSync
  logic ceSync; // synchronised chip enable

  // two flops per level; the host holds sclk still while le is high,
  // so the shift register is static when its rising edge is seen
  always_ff @(posedge clk) begin
    if (srst) begin
      leMeta <= 1'b0;
      leSync <= 1'b0;
      leLast <= 1'b0;
      ceMeta <= 1'b0;
      ceSync <= 1'b0;
    end else begin
      leMeta <= latchEnablePin;
      leSync <= leMeta;
      leLast <= leSync;
      ceMeta <= chipEnablePin;
      ceSync <= ceMeta;
    end
  end

  logic wordStrobe; // one cycle on a synchronised rising latch enable
  assign wordStrobe = leSync & ~leLast;

  // ---------------- latch decode ----------------
  logic [WORD_W-1:0] funcWord; // function configuration latch
  pfl_func_t cfg; // decoded view of the latch
  logic loadFunc; // function or init word arrives
  logic loadInit; // init word arrives
  logic loadFb; // feedback counter word arrives

  assign loadInit = wordStrobe & latchIs(shiftReg, SEL_INIT);
  assign loadFunc = wordStrobe & (latchIs(shiftReg, SEL_FUNC) | loadInit);
  assign loadFb = wordStrobe & latchIs(shiftReg, SEL_FB);

  assign cfg.counterHold = funcWord[POS_HOLD];
  assign cfg.powerdownRequest = funcWord[POS_PDREQ];
  assign cfg.monitorSelect = funcWord[POS_MON_LO +: 3];
  assign cfg.pdPolarity = funcWord[POS_PDPOL];
  assign cfg.chargePumpTri = funcWord[POS_TRI];
  assign cfg.fastEnable = funcWord[POS_FAST_EN];
  assign cfg.fastMode = funcWord[POS_FAST_MODE];
  assign cfg.timeoutSelect = funcWord[POS_TMO_LO +: 4];
  assign cfg.primaryCurrentCode = funcWord[POS_PRI_LO +: 3];
  assign cfg.secondaryCurrentCode = funcWord[POS_SEC_LO +: 3];
  assign cfg.powerdownSyncSelect = funcWord[POS_PDSYNC];
  assign cfg.prescalerSelect = funcWord[POS_PRE_LO +: 2];

  // function latch; only srst clears it, chip enable leaves it alone
  always_ff @(posedge clk) begin
    if (srst) begin
      funcWord <= FUNC_RST;
    end else if (loadFunc) begin
      funcWord <= shiftReg;
    end
  end

  // every captured word handed onward, with load strobes for the reference and feedback latches
  always_ff @(posedge clk) begin
    if (srst) begin
      counterWord <= '0;
      refLoad <= 1'b0;
      fbLoad <= 1'b0;
    end else begin
      refLoad <= wordStrobe & latchIs(shiftReg, SEL_REF);
      fbLoad <= loadFb;
      if (wordStrobe) begin
        counterWord <= shiftReg;
      end
    end
  end

  // ---------------- internal reset pulse ----------------
  logic fbArmed; // next feedback load re-issues the pulse
  logic initPulse; // one-cycle internal reset pulse

  // armed by an init word, spent by the first feedback load after it
  always_ff @(posedge clk) begin
    if (srst) begin
      fbArmed <= 1'b0;
      initPulse <= 1'b0;
    end else begin
      initPulse <= loadInit | (loadFb & fbArmed);
      if (loadInit) begin
        fbArmed <= 1'b1;
      end else if (loadFb) begin
        fbArmed <= 1'b0;
      end
    end
  end

  // ---------------- power-down ----------------
  logic swPowerDown; // programmed power-down in effect

  // async: immediate on the request; sync: waits for a pump event or
  // for the init pulse; dropping the request ends it
  always_ff @(posedge clk) begin
    if (srst) begin
      swPowerDown <= 1'b0;
    end else if (!cfg.powerdownRequest) begin
      swPowerDown <= 1'b0;
    end else if (!cfg.powerdownSyncSelect) begin
      swPowerDown <= 1'b1;
    end else if (chargePumpEvent | initPulse) begin
      swPowerDown <= 1'b1;
    end
  end

  // the pin wins over both programmed bits
  assign powerDown = ~ceSync | swPowerDown;

  // ---------------- fast acquisition ----------------
  logic gainBit; // fast-acquire gain bit copy
  logic timerMode; // timer-exited variant selected
  logic [5:0] timeoutCnt; // phase detector cycles spent in fast mode
  logic timeoutHit; // timeout reached this cycle

  assign timerMode = cfg.fastEnable & cfg.fastMode;
  assign timeoutHit = timerMode & gainBit & pfdTick
    & (timeoutCnt == timeoutLen(cfg.timeoutSelect) - 6'h01);

  // gain bit follows each feedback write; in timer mode the timeout
  // clears it, but a feedback write in that same cycle wins
  always_ff @(posedge clk) begin
    if (srst) begin
      gainBit <= 1'b0;
    end else if (loadFb) begin
      gainBit <= shiftReg[POS_GAIN];
    end else if (timeoutHit) begin
      gainBit <= 1'b0;
    end
  end

  // counter parked unless timer mode is running fast; forced to load
  // state by power-down and by the internal pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      timeoutCnt <= '0;
    end else if (!timerMode || !gainBit || powerDown || initPulse || loadFb) begin
      timeoutCnt <= '0;
    end else if (timeoutHit) begin
      timeoutCnt <= '0;
    end else if (pfdTick) begin
      timeoutCnt <= timeoutCnt + 6'h01;
    end
  end

  assign fastActive = cfg.fastEnable & gainBit;

  // ---------------- analog controls ----------------
  // the pulse touches only counters and pump; reference and input
  // buffer stay up so phase alignment survives
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= '{default: 1'b1};
      chargePumpCurrent <= '0;
      prescalerSelect <= '0;
      pdPolarity <= 1'b0;
    end else begin
      ctrl.counterLoad <= cfg.counterHold | powerDown | initPulse;
      ctrl.timeoutLoad <= powerDown | initPulse;
      ctrl.chargePumpHighZ <= cfg.chargePumpTri | cfg.counterHold
        | powerDown | initPulse;
      ctrl.lockDetectReset <= powerDown;
      ctrl.rfDebias <= powerDown;
      ctrl.refBufferOff <= powerDown;
      chargePumpCurrent <= fastActive ? cfg.secondaryCurrentCode
        : cfg.primaryCurrentCode;
      prescalerSelect <= cfg.prescalerSelect;
      pdPolarity <= cfg.pdPolarity;
    end
  end

  // ---------------- monitor output ----------------
  logic next_monitor; // selected internal signal

  // multiplexer onto the monitor pin; unused codes read low
  always_comb begin
    unique case (cfg.monitorSelect)
      MON_LOW: next_monitor = 1'b0;
      MON_LOCK: next_monitor = lockDetect;
      MON_FBDIV: next_monitor = fbDivOut;
      MON_HIGH: next_monitor = 1'b1;
      MON_REFDIV: next_monitor = refDivOut;
      MON_NLOCK: next_monitor = ~lockDetect;
      MON_FAST: next_monitor = fastActive;
      default: next_monitor = 1'b0;
    endcase
  end

  // registered so the pin never glitches between inputs
  always_ff @(posedge clk) begin
    if (srst) begin
      monitorOutputPin <= 1'b0;
    end else begin
      monitorOutputPin <= next_monitor;
    end
  end

  // ---------------- assertions ----------------
  a_func_load: assert property (@(posedge clk) disable iff (srst)
    wordStrobe && latchIs(shiftReg, SEL_FUNC) |=> funcWord == $past(shiftReg))
    else $error("function word not loaded");

  a_ref_ignore: assert property (@(posedge clk) disable iff (srst)
    wordStrobe && latchIs(shiftReg, SEL_REF) |=> $stable(funcWord))
    else $error("reference word changed function latch");

  a_ce_powerdown: assert property (@(posedge clk) disable iff (srst)
    !ceSync |-> powerDown ##1 ctrl.counterLoad && ctrl.chargePumpHighZ)
    else $error("chip enable low did not power down");

  a_async_pd: assert property (@(posedge clk) disable iff (srst)
    loadFunc && shiftReg[POS_PDREQ] && !shiftReg[POS_PDSYNC] |=> ##1 powerDown)
    else $error("async power-down late");

  a_sync_wait: assert property (@(posedge clk) disable iff (srst)
    ceSync && cfg.powerdownRequest && cfg.powerdownSyncSelect && !swPowerDown
    && !chargePumpEvent && !initPulse |=> !swPowerDown)
    else $error("sync power-down before pump event");

  a_pd_effects: assert property (@(posedge clk) disable iff (srst)
    powerDown |=> ctrl.timeoutLoad && ctrl.lockDetectReset && ctrl.rfDebias
    && ctrl.refBufferOff)
    else $error("power-down effects missing");

  a_init_pulse: assert property (@(posedge clk) disable iff (srst)
    loadInit |=> initPulse ##1 ctrl.counterLoad && ctrl.chargePumpHighZ)
    else $error("init word gave no reset pulse");

  a_fb_repulse: assert property (@(posedge clk) disable iff (srst)
    loadFb && !fbArmed && !loadInit |=> !initPulse)
    else $error("unarmed feedback load pulsed");

  a_current_sel: assert property (@(posedge clk) disable iff (srst)
    ##1 chargePumpCurrent == ($past(fastActive) ? $past(cfg.secondaryCurrentCode)
    : $past(cfg.primaryCurrentCode)))
    else $error("wrong pump current code");

  a_timer_idle: assert property (@(posedge clk) disable iff (srst)
    !timerMode |=> timeoutCnt == 6'h00)
    else $error("timeout counter ran outside timer mode");

  a_timer_clear: assert property (@(posedge clk) disable iff (srst)
    timeoutHit && !loadFb |=> !gainBit)
    else $error("gain not cleared at timeout");

  a_tri_state: assert property (@(posedge clk) disable iff (srst)
    cfg.chargePumpTri |=> ctrl.chargePumpHighZ)
    else $error("pump not three-stated");

  // counter hold parks the counters and floats the pump, no power-down
  a_hold_load: assert property (@(posedge clk) disable iff (srst)
    cfg.counterHold |=> ctrl.counterLoad && ctrl.chargePumpHighZ)
    else $error("hold bit did not park counters");

  // armed sync power-down takes the pump event
  a_sync_event: assert property (@(posedge clk) disable iff (srst)
    cfg.powerdownRequest && cfg.powerdownSyncSelect && chargePumpEvent |=> swPowerDown)
    else $error("sync power-down missed pump event");

  // armed sync power-down also takes the internal pulse
  a_sync_init: assert property (@(posedge clk) disable iff (srst)
    cfg.powerdownRequest && cfg.powerdownSyncSelect && initPulse |=> swPowerDown)
    else $error("init pulse did not trigger power-down");

  // a gain write of one enters fast acquisition when enabled
  a_fast_enter: assert property (@(posedge clk) disable iff (srst)
    loadFb && shiftReg[POS_GAIN] && cfg.fastEnable |=> fastActive)
    else $error("gain write did not enter fast mode");

  // the pulse alone must leave input bias and reference buffer up
  a_pulse_spares: assert property (@(posedge clk) disable iff (srst)
    initPulse && !powerDown |=> !ctrl.rfDebias && !ctrl.refBufferOff)
    else $error("reset pulse touched reference or input");

  // the armed feedback load repeats the pulse
  a_fb_armed: assert property (@(posedge clk) disable iff (srst)
    loadFb && fbArmed |=> initPulse)
    else $error("first feedback load gave no pulse");

  // words are still taken while chip enable holds the part down
  a_input_live: assert property (@(posedge clk) disable iff (srst)
    !ceSync && wordStrobe |=> counterWord == $past(shiftReg))
    else $error("word lost during power-down");

  // a fixed monitor code drives the pin high
  a_monitor_high: assert property (@(posedge clk) disable iff (srst)
    cfg.monitorSelect == MON_HIGH |=> monitorOutputPin)
    else $error("monitor pin not high");

  // only a function or init word may alter the latch
  a_latch_keep: assert property (@(posedge clk) disable iff (srst)
    !loadFunc |=> $stable(funcWord))
    else $error("function latch changed without a word");

  c_init_seq: cover property (@(posedge clk) disable iff (srst)
    loadInit ##[1:200] (loadFb && fbArmed));
  c_sync_pd: cover property (@(posedge clk) disable iff (srst)
    cfg.powerdownSyncSelect && chargePumpEvent && !swPowerDown ##1 swPowerDown);
  c_timeout: cover property (@(posedge clk) disable iff (srst)
    timeoutHit);
  c_ce_cycle: cover property (@(posedge clk) disable iff (srst)
    !ceSync ##1 ceSync);
  c_fast_manual: cover property (@(posedge clk) disable iff (srst)
    fastActive && !timerMode);

endmodule

// [rtl/pfl_pkg.sv]
package pfl_pkg;
  // serial word geometry
  localparam int WORD_W = 24;
  localparam int SEL_W = 2;
  // latch select codes in the two low bits
  localparam logic [1:0] SEL_REF = 2'h0;
  localparam logic [1:0] SEL_FB = 2'h1;
  localparam logic [1:0] SEL_FUNC = 2'h2;
  localparam logic [1:0] SEL_INIT = 2'h3;
  // function / initialization word field positions
  localparam int POS_HOLD = 2;
  localparam int POS_PDREQ = 3;
  localparam int POS_MON_LO = 4;
  localparam int POS_PDPOL = 7;
  localparam int POS_TRI = 8;
  localparam int POS_FAST_EN = 9;
  localparam int POS_FAST_MODE = 10;
  localparam int POS_TMO_LO = 11;
  localparam int POS_PRI_LO = 15;
  localparam int POS_SEC_LO = 18;
  localparam int POS_PDSYNC = 21;
  localparam int POS_PRE_LO = 22;
  // gain bit inside the feedback counter word
  localparam int POS_GAIN = 21;
  // timeout periods in phase detector cycles: base plus step per code
  localparam logic [5:0] TMO_BASE = 6'h03;
  localparam logic [5:0] TMO_STEP = 6'h04;
  // monitor select codes
  localparam logic [2:0] MON_LOW = 3'h0;
  localparam logic [2:0] MON_LOCK = 3'h1;
  localparam logic [2:0] MON_FBDIV = 3'h2;
  localparam logic [2:0] MON_HIGH = 3'h3;
  localparam logic [2:0] MON_REFDIV = 3'h4;
  localparam logic [2:0] MON_NLOCK = 3'h5;
  localparam logic [2:0] MON_FAST = 3'h6;
  // reset value of the configuration latch: everything off
  localparam logic [WORD_W-1:0] FUNC_RST = 24'h000000;

  // decoded configuration fields
  typedef struct packed {
    logic [1:0] prescalerSelect;
    logic powerdownSyncSelect;
    logic [2:0] secondaryCurrentCode;
    logic [2:0] primaryCurrentCode;
    logic [3:0] timeoutSelect;
    logic fastMode;
    logic fastEnable;
    logic chargePumpTri;
    logic pdPolarity;
    logic [2:0] monitorSelect;
    logic powerdownRequest;
    logic counterHold;
  } pfl_func_t;

  // analog-side controls driven by the block
  typedef struct packed {
    logic counterLoad;
    logic timeoutLoad;
    logic chargePumpHighZ;
    logic lockDetectReset;
    logic rfDebias;
    logic refBufferOff;
  } pfl_ctrl_t;
endpackage

// [tb/pfl_host_model.sv]
`timescale 1ns/100ps
// host side of the three-wire link: shifts whole words, then pulses latch enable
module pfl_host_model
  import pfl_pkg::*;
(
  output logic serialClk,
  output logic serialData,
  output logic latchEnablePin
);
  // link clock stands still between frames
  initial begin
    serialClk = 1'h0;
    serialData = 1'h0;
    latchEnablePin = 1'h0;
  end
  // one 24-bit word, msb first, data moves while the clock is low
  task automatic send(input logic [WORD_W-1:0] word);
    for (int i = WORD_W - 1; i >= 0; i--) begin
      serialData = word[i];
      #3 serialClk = 1'h1;
      #3 serialClk = 1'h0;
    end
    // no pull on the data line, so park it away from the last bit
    serialData = ~word[0];
    #10 latchEnablePin = 1'h1;
    // clock stays still while the sync flops take the word
    #100 latchEnablePin = 1'h0;
    #100;
  endtask
endmodule

// [tb/pfl_function_ctrl_tb_top.sv]
`timescale 1ns/100ps
module pfl_function_ctrl_tb_top
  import pfl_pkg::*;
;
  // table row: function fields beside the monitor level they give
  typedef struct packed {
    logic [2:0] mon;
    logic [2:0] pri;
    logic [1:0] pre;
    logic pol;
    logic hiz;
    logic expMon;
  } pfl_row_t;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic chipEnablePin = 1'h1;
  logic chargePumpEvent = 1'h0;
  logic pfdTick = 1'h0;
  // monitor sources parked at fixed levels: lock and reference divider high, feedback divider low
  logic lockDetect = 1'h1;
  logic refDivOut = 1'h1;
  logic fbDivOut = 1'h0;
  logic serialClk, serialData, latchEnablePin;
  logic monitorOutputPin, powerDown, pdPolarity, fastActive, refLoad, fbLoad;
  pfl_ctrl_t ctrl;
  logic [2:0] chargePumpCurrent;
  logic [1:0] prescalerSelect;
  logic [WORD_W-1:0] counterWord;
  // sticky catches of one-cycle events
  logic seenLoad = 1'h0;
  logic seenHighZ = 1'h0;
  logic seenBufOff = 1'h0;
  logic seenFb = 1'h0;
  logic seenRef = 1'h0;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  pfl_row_t rows [8] = '{
    '{3'h0, 3'h3, 2'h1, 1'h1, 1'h0, 1'h0}, '{3'h1, 3'h7, 2'h2, 1'h0, 1'h1, 1'h1},
    '{3'h2, 3'h0, 2'h3, 1'h1, 1'h0, 1'h0}, '{3'h3, 3'h4, 2'h0, 1'h0, 1'h1, 1'h1},
    '{3'h4, 3'h2, 2'h1, 1'h0, 1'h0, 1'h1}, '{3'h5, 3'h5, 2'h2, 1'h1, 1'h1, 1'h0},
    '{3'h6, 3'h6, 2'h3, 1'h0, 1'h0, 1'h0}, '{3'h7, 3'h1, 2'h0, 1'h1, 1'h1, 1'h0}};

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  pfl_host_model i_host (
    .serialClk(serialClk),
    .serialData(serialData),
    .latchEnablePin(latchEnablePin)
  );

  pfl_function_ctrl i_dut (
    .clk(clk), .srst(srst), .serialClk(serialClk), .serialData(serialData),
    .latchEnablePin(latchEnablePin), .chipEnablePin(chipEnablePin),
    .chargePumpEvent(chargePumpEvent), .pfdTick(pfdTick), .lockDetect(lockDetect),
    .refDivOut(refDivOut), .fbDivOut(fbDivOut), .monitorOutputPin(monitorOutputPin),
    .ctrl(ctrl), .powerDown(powerDown), .chargePumpCurrent(chargePumpCurrent),
    .prescalerSelect(prescalerSelect), .pdPolarity(pdPolarity), .fastActive(fastActive),
    .refLoad(refLoad), .fbLoad(fbLoad), .counterWord(counterWord)
  );

  // event catches and the hang guard; the whole run needs about 570 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (ctrl.counterLoad === 1'h1) seenLoad <= 1'h1;
    if (ctrl.chargePumpHighZ === 1'h1) seenHighZ <= 1'h1;
    if (ctrl.refBufferOff === 1'h1) seenBufOff <= 1'h1;
    if (fbLoad === 1'h1) seenFb <= 1'h1;
    if (refLoad === 1'h1) seenRef <= 1'h1;
    if (cycles == 6000) begin
      failures++;
      give_verdict();
    end
  end

  // inputs set after a tick move 1 ns after the rising edge; the serial pins keep the host's own timing
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle pulse on the pump event or the phase detector tick
  task automatic pulse(input logic pump);
    if (pump) chargePumpEvent = 1'h1;
    else pfdTick = 1'h1;
    tick(1);
    chargePumpEvent = 1'h0;
    pfdTick = 1'h0;
    tick(1);
  endtask
  // a word plus settling; latch updates land well inside this
  task automatic put(input logic [WORD_W-1:0] w);
    i_host.send(w);
    tick(3);
  endtask
  task automatic clr();
    seenLoad = 1'h0;
    seenHighZ = 1'h0;
    seenBufOff = 1'h0;
    seenFb = 1'h0;
    seenRef = 1'h0;
  endtask
  task automatic chk(input string n, input logic e, input logic g);
    checked++;
    if (e !== g) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chkv(input string n, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
    checked++;
    if (e !== g) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic endt(input string n);
    $display("test %s done, %0d failures so far", n, failures);
  endtask
  task automatic give_verdict();
    $display("checked %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // function word; flg is {pd sync, fast mode, fast en, three-state, polarity, pd req, hold}
  function automatic logic [WORD_W-1:0] fw(input logic [1:0] pre, input logic [2:0] sec,
      input logic [2:0] pri, input logic [3:0] tmo, input logic [2:0] mon, input logic [6:0] flg);
    fw = {pre, flg[6], sec, pri, tmo, flg[5:3], flg[2], mon, flg[1:0], SEL_FUNC};
  endfunction
  // feedback word with the gain bit at 21
  function automatic logic [WORD_W-1:0] fb(input logic g);
    fb = {2'h0, g, 19'h00ABC, SEL_FB};
  endfunction

  initial begin
    logic [WORD_W-1:0] w;
    tick(16);
    chkv("ctrlInReset", 24'h00003F, 24'(ctrl));
    chk("pdInReset", 1'h1, powerDown);
    srst = 1'h0;
    tick(4);
    chk("pdAfterReset", 1'h0, powerDown);
    chkv("ctrlAfterReset", 24'h000000, 24'(ctrl));
    endt("reset");
    foreach (rows[i]) begin
      w = fw(rows[i].pre, 3'h7, rows[i].pri, 4'h0, rows[i].mon, {3'h0, rows[i].hiz, rows[i].pol, 2'h0});
      put(w);
      chk("monitor", rows[i].expMon, monitorOutputPin);
      chkv("current", 24'(rows[i].pri), 24'(chargePumpCurrent));
      chkv("prescaler", 24'(rows[i].pre), 24'(prescalerSelect));
      chk("polarity", rows[i].pol, pdPolarity);
      chk("pumpHighZ", rows[i].hiz, ctrl.chargePumpHighZ);
      chkv("counterWord", w, counterWord);
    end
    endt("table");
    // program everything with chip enable low, in function, reference, feedback order
    chipEnablePin = 1'h0;
    tick(3);
    chk("pdChipEnable", 1'h1, powerDown);
    tick(1);
    chkv("ctrlChipEnable", 24'h00003F, 24'(ctrl));
    put(fw(2'h1, 3'h2, 3'h5, 4'h0, 3'h0, 7'h00));
    put({22'h000500, SEL_REF});
    w = fb(1'h0);
    put(w);
    chkv("wordWhileDown", w, counterWord);
    chipEnablePin = 1'h1;
    tick(4);
    chk("pdReleased", 1'h0, powerDown);
    chkv("currentKept", 24'h000005, 24'(chargePumpCurrent));
    chipEnablePin = 1'h0;
    tick(4);
    chipEnablePin = 1'h1;
    tick(4);
    chkv("currentCycled", 24'h000005, 24'(chargePumpCurrent));
    endt("chip enable");
    put(fw(2'h1, 3'h2, 3'h5, 4'h0, 3'h0, 7'h02));
    chk("pdAsync", 1'h1, powerDown);
    chkv("ctrlAsync", 24'h00003F, 24'(ctrl));
    put(fw(2'h1, 3'h2, 3'h5, 4'h0, 3'h0, 7'h00));
    chk("pdAsyncOff", 1'h0, powerDown);
    put(fw(2'h1, 3'h2, 3'h5, 4'h0, 3'h0, 7'h42));
    chk("pdSyncWaits", 1'h0, powerDown);
    pulse(1'h1);
    tick(1);
    chk("pdSyncEvent", 1'h1, powerDown);
    put(fw(2'h1, 3'h2, 3'h5, 4'h0, 3'h0, 7'h01));
    chk("pdCleared", 1'h0, powerDown);
    chk("holdLoad", 1'h1, ctrl.counterLoad);
    put(fw(2'h1, 3'h2, 3'h5, 4'h0, 3'h0, 7'h00));
    chk("holdFree", 1'h0, ctrl.counterLoad);
    endt("power-down");
    // manual fast exit: ticks must not end it
    put(fw(2'h1, 3'h6, 3'h1, 4'h1, 3'h6, 7'h10));
    put(fb(1'h1));
    chk("fastOn", 1'h1, fastActive);
    chk("monFast", 1'h1, monitorOutputPin);
    chkv("secCurrent", 24'h000006, 24'(chargePumpCurrent));
    repeat (10) pulse(1'h0);
    chkv("manualHolds", 24'h000006, 24'(chargePumpCurrent));
    put(fb(1'h0));
    chkv("manualExit", 24'h000001, 24'(chargePumpCurrent));
    put(fw(2'h1, 3'h6, 3'h1, 4'h1, 3'h0, 7'h00));
    put(fb(1'h1));
    chk("fastDisabled", 1'h0, fastActive);
    chkv("priCurrent", 24'h000001, 24'(chargePumpCurrent));
    put(fb(1'h0));
    // timer exit after 3 + 4 * 1 = 7 ticks
    put(fw(2'h1, 3'h6, 3'h1, 4'h1, 3'h0, 7'h30));
    put(fb(1'h1));
    chkv("timerOn", 24'h000006, 24'(chargePumpCurrent));
    repeat (6) pulse(1'h0);
    chkv("timerSix", 24'h000006, 24'(chargePumpCurrent));
    pulse(1'h0);
    tick(2);
    chkv("timerExit", 24'h000001, 24'(chargePumpCurrent));
    chk("gainCleared", 1'h0, fastActive);
    endt("fast acquisition");
    // initialization, then reference, then feedback
    clr();
    w = fw(2'h0, 3'h0, 3'h2, 4'h0, 3'h0, 7'h00);
    w[1:0] = SEL_INIT;
    put(w);
    chk("initPulse", 1'h1, seenLoad);
    chk("initHighZ", 1'h1, seenHighZ);
    chk("bufferKept", 1'h0, seenBufOff);
    chkv("initLoads", 24'h000002, 24'(chargePumpCurrent));
    clr();
    put({22'h000500, SEL_REF});
    chk("refLoad", 1'h1, seenRef);
    chk("refNoPulse", 1'h0, seenLoad);
    clr();
    put(fb(1'h0));
    chk("firstFbPulse", 1'h1, seenLoad);
    chk("fbLoad", 1'h1, seenFb);
    clr();
    put(fb(1'h0));
    chk("laterFbQuiet", 1'h0, seenLoad);
    w = fw(2'h0, 3'h0, 3'h2, 4'h0, 3'h0, 7'h42);
    w[1:0] = SEL_INIT;
    put(w);
    chk("initSyncPd", 1'h1, powerDown);
    endt("initialization");
    give_verdict();
  end
endmodule
